/* File: inc/fcrb_pkg.sv */
package fcrb_pkg;
   // register byte addresses on the command link
   localparam logic [31:0] ADDR_BUS_MODE = 32'h00000000;
   localparam logic [31:0] ADDR_STROBE = 32'h00000200;
   localparam logic [31:0] ADDR_DUMMY = 32'h00000300;
   localparam logic [31:0] ADDR_ERR_PIN = 32'h00000400;
   localparam logic [31:0] ADDR_CRC_PRE = 32'h00000500;
   localparam logic [31:0] ADDR_ECC_STAT = 32'h00000800;
   localparam logic [31:0] ADDR_ECC_A0 = 32'h00000c00;
   localparam logic [31:0] ADDR_ECC_A1 = 32'h00000d00;
   localparam logic [31:0] ADDR_ECC_A2 = 32'h00000e00;
   localparam logic [31:0] ADDR_ECC_A3 = 32'h00000f00;
   localparam logic [31:0] ADDR_BOOT_DEF = 32'h40000000;
   localparam logic [31:0] ADDR_CMD_ERR = 32'h80000000;

   // bus mode codes
   localparam logic [1:0] MODE_SPI = 2'h0;
   localparam logic [1:0] MODE_SRO = 2'h1;
   localparam logic [1:0] MODE_DRO = 2'h2;
   localparam logic [1:0] BOOT_INHIBIT = 2'h0;

   // field positions
   localparam int STRB_SINGLE_BIT = 1;
   localparam int STRB_PRE_BIT = 0;
   localparam int CRC_SIZE_LSB = 5;
   localparam int CRC_PIN_BIT = 4;
   localparam int PRE_CHOICE_BIT = 0;
   localparam int ECC_VALID_BIT = 7;
   localparam int ECC_KIND_LSB = 4;
   localparam int ECC_A0_LSB = 4;
   localparam int PARITY_OFF_BIT = 3;
   localparam int CMD_FAIL_BIT = 4;
   localparam int KIND_ONE_BIT = 0;
   localparam int KIND_TWO_BIT = 1;
   localparam int KIND_DBL_BIT = 2;

   // reset and fixed values
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] CLEAR_VALUE = 8'h00;
   localparam logic [7:0] BOOT_RSV_ONES = 8'hf4;
   localparam logic [3:0] ECC_CNT_MAX = 4'hf;
   localparam logic [4:0] DUMMY_BASE = 5'h14;
   localparam logic [7:0] CHUNK_MIN_BYTES = 8'h10;
   localparam logic [15:0] PRE_A_MAIN = 16'h349a;
   localparam logic [15:0] PRE_A_SIO3 = 16'h3514;
   localparam logic [15:0] PRE_B_ALL = 16'h5555;
   localparam logic [1:0] BOOT_SETTLE = 2'h2;

   // error pin conditions
   localparam logic [1:0] EPC_TWO_OR_DBL = 2'h0;
   localparam logic [1:0] EPC_ANY = 2'h1;
   localparam logic [1:0] EPC_TWO = 2'h2;

   typedef enum logic [2:0] {
      FCRB_BOOT_WAIT = 3'b001,
      FCRB_BOOT_LOAD = 3'b010,
      FCRB_RUN = 3'b100
   } fcrb_boot_t;

   typedef struct packed {
      logic write;
      logic [31:0] addr;
      logic [7:0] wdata;
   } fcrb_link_req_t;

   typedef struct packed {
      logic [2:0] kind;
      logic [25:4] addr;
   } fcrb_ecc_evt_t;

   typedef struct packed {
      logic parity_off_n;
      logic boot_dro_n;
      logic boot_sro_n;
   } fcrb_otp_t;

   localparam fcrb_otp_t OTP_BLANK = 3'h7;
endpackage

/* File: logic/fcrb_sync2.sv */
`timescale 1ns/1ns
`default_nettype none
module fcrb_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] stage_reg;

   // first stage feeds only the second
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stage_reg <= '0;
         q <= '0;
      end else begin
         stage_reg <= d;
         q <= stage_reg;
      end
   end
endmodule // fcrb_sync2
`default_nettype wire

/* File: logic/fcrb_regbank.sv */
// Notes on behaviour
// - two-bit mode field selects spi, sro, dro
// - mode loaded from stored boot bits at reset
// - boot pair active low, 00 inhibited
// - stored bit 3 low enables parity checking
// - check failure sets read-only flag bit 4
// - writing 00 clears the check failure flag
// - condition field picks when error pin drops
// - bits 6-5 pick crc chunk 16 to 128
// - bit 4 turns the crc pin on
// - valid bit 7 shows address recorded
// - fail kind bits: one, two, double program
// - fail counter counts every fail, saturates 15
// - only first failing chunk address kept
// - writing 00 clears valid, kinds and count, not the address
// - dummy code gives 20 down to 6 cycles
// - preamble enable drives pattern in dummy cycles
`timescale 1ns/1ns
`default_nettype none
module fcrb_regbank (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic link_clk,
   input wire logic link_req_valid,
   input wire fcrb_pkg::fcrb_link_req_t link_req,
   output logic link_busy,
   output logic link_ack,
   output logic [7:0] link_rdata,
   input wire logic ecc_evt_valid,
   input wire fcrb_pkg::fcrb_ecc_evt_t ecc_evt,
   input wire logic cmd_check_fail,
   input wire fcrb_pkg::fcrb_otp_t otp_fuse,
   input wire logic preamble_on,
   output logic otp_prog_valid,
   output fcrb_pkg::fcrb_otp_t otp_prog_data,
   output logic [1:0] bus_mode,
   output logic strobe_in_single_rate,
   output logic strobe_pre_cycle,
   output logic [4:0] dummy_cycles,
   output logic error_out_pin_n,
   output logic [7:0] crc_chunk_bytes,
   output logic crc_pin_output_on,
   output logic preamble_active,
   output logic [15:0] preamble_main,
   output logic [15:0] preamble_sio3,
   output logic parity_check_on,
   output logic cmd_parity_fail_flag,
   output logic ecc_fail_addr_valid
);
   import fcrb_pkg::*;

   // link domain: capture one request, hold it until the core answers
   fcrb_link_req_t hold_reg;
   logic req_tgl_reg;
   logic ack_seen_reg;
   logic ack_tgl_sync;

   // core domain
   fcrb_boot_t boot_reg;
   logic [1:0] boot_cnt_reg;
   logic req_seen_reg;
   logic req_tgl_sync;
   logic ack_tgl_reg;
   logic [7:0] rdata_hold_reg;
   fcrb_otp_t fuse_sync;
   fcrb_otp_t otp_reg;
   logic preamble_on_sync;
   logic [7:0] strobe_reg;
   logic [7:0] dummy_reg;
   logic [7:0] err_pin_reg;
   logic [7:0] crc_pre_reg;
   logic ecc_valid_reg;
   logic [2:0] ecc_kind_reg;
   logic [3:0] ecc_cnt_reg;
   logic [25:4] ecc_addr_reg;
   logic cmd_fail_reg;
   logic access;
   logic wr_hit;
   logic [7:0] rd_value;
   logic ecc_clear;
   logic err_match;

   fcrb_sync2 #(.WIDTH(1)) u_ack_sync (
      .clk(link_clk),
      .reset_n(reset_n),
      .d(ack_tgl_reg),
      .q(ack_tgl_sync)
   );

   fcrb_sync2 #(.WIDTH(1)) u_req_sync (
      .clk(core_clk),
      .reset_n(reset_n),
      .d(req_tgl_reg),
      .q(req_tgl_sync)
   );

   fcrb_sync2 #(.WIDTH(4)) u_pin_sync (
      .clk(core_clk),
      .reset_n(reset_n),
      .d({otp_fuse, preamble_on}),
      .q({fuse_sync, preamble_on_sync})
   );

   // requests arriving while busy are dropped; the host waits for ack
   // the ack cycle is excluded too: the host still holds its request there
   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         hold_reg <= '0;
         req_tgl_reg <= 1'b0;
         link_busy <= 1'b0;
      end else if (link_req_valid && !link_busy && !link_ack) begin
         hold_reg <= link_req;
         req_tgl_reg <= ~req_tgl_reg;
         link_busy <= 1'b1;
      end else if (ack_tgl_sync != ack_seen_reg) begin
         link_busy <= 1'b0;
      end
   end

   // read data is stable in the core while the ack toggle travels
   always_ff @(posedge link_clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_seen_reg <= 1'b0;
         link_ack <= 1'b0;
         link_rdata <= REG_RESET;
      end else begin
         ack_seen_reg <= ack_tgl_sync;
         link_ack <= ack_tgl_sync != ack_seen_reg;
         if (ack_tgl_sync != ack_seen_reg) begin
            link_rdata <= rdata_hold_reg;
         end
      end
   end

   // boot: wait for fuse sync, then load mode from stored defaults
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         boot_reg <= FCRB_BOOT_WAIT;
         boot_cnt_reg <= 2'h0;
      end else begin
         case (boot_reg)
            FCRB_BOOT_WAIT: begin
               boot_cnt_reg <= boot_cnt_reg + 2'h1;
               if (boot_cnt_reg == BOOT_SETTLE) begin
                  boot_reg <= FCRB_BOOT_LOAD;
               end
            end
            FCRB_BOOT_LOAD: boot_reg <= FCRB_RUN;
            FCRB_RUN: boot_reg <= FCRB_RUN;
            default: boot_reg <= FCRB_BOOT_WAIT;
         endcase
      end
   end

   // a pending request is only served once boot is done
   assign access = (boot_reg == FCRB_RUN) && (req_tgl_sync != req_seen_reg);
   assign wr_hit = access && hold_reg.write;
   assign ecc_clear = wr_hit && hold_reg.addr == ADDR_ECC_STAT &&
      hold_reg.wdata == CLEAR_VALUE;

   always_comb begin
      rd_value = REG_RESET;
      case (hold_reg.addr)
         ADDR_BUS_MODE: rd_value = {6'h00, bus_mode};
         ADDR_STROBE: rd_value = strobe_reg;
         ADDR_DUMMY: rd_value = dummy_reg;
         ADDR_ERR_PIN: rd_value = err_pin_reg;
         ADDR_CRC_PRE: rd_value = crc_pre_reg;
         ADDR_ECC_STAT: rd_value = {ecc_valid_reg, ecc_kind_reg, ecc_cnt_reg};
         ADDR_ECC_A0: rd_value = {ecc_addr_reg[7:4], 4'h0};
         ADDR_ECC_A1: rd_value = ecc_addr_reg[15:8];
         ADDR_ECC_A2: rd_value = ecc_addr_reg[23:16];
         ADDR_ECC_A3: rd_value = {6'h00, ecc_addr_reg[25:24]};
         ADDR_BOOT_DEF: begin
            rd_value = BOOT_RSV_ONES;
            rd_value[PARITY_OFF_BIT] = otp_reg.parity_off_n;
            rd_value[1:0] = {otp_reg.boot_dro_n, otp_reg.boot_sro_n};
         end
         ADDR_CMD_ERR: begin
            rd_value = REG_RESET;
            rd_value[CMD_FAIL_BIT] = cmd_fail_reg;
         end
         default: rd_value = REG_RESET;
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         req_seen_reg <= 1'b0;
         ack_tgl_reg <= 1'b0;
         rdata_hold_reg <= REG_RESET;
      end else if (access) begin
         req_seen_reg <= req_tgl_sync;
         ack_tgl_reg <= ~ack_tgl_reg;
         rdata_hold_reg <= hold_reg.write ? rdata_hold_reg : rd_value;
      end
   end

   // mode: loaded from active-low boot pair, then host writable
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         bus_mode <= MODE_SPI;
      end else if (boot_reg == FCRB_BOOT_LOAD) begin
         if ({otp_reg.boot_dro_n, otp_reg.boot_sro_n} == BOOT_INHIBIT) begin
            bus_mode <= MODE_SPI;
         end else begin
            bus_mode <= ~{otp_reg.boot_dro_n, otp_reg.boot_sro_n};
         end
      end else if (wr_hit && hold_reg.addr == ADDR_BUS_MODE) begin
         // no guard on sro<->dro; the host passes through spi first
         bus_mode <= hold_reg.wdata[1:0];
      end
   end

   // stored defaults: captured after reset, writes only program ones to 0
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         otp_reg <= OTP_BLANK;
         otp_prog_valid <= 1'b0;
         otp_prog_data <= OTP_BLANK;
      end else begin
         otp_prog_valid <= 1'b0;
         if (boot_reg == FCRB_BOOT_WAIT) begin
            otp_reg <= fuse_sync;
         end else if (wr_hit && hold_reg.addr == ADDR_BOOT_DEF) begin
            otp_reg <= otp_reg & {hold_reg.wdata[PARITY_OFF_BIT],
               hold_reg.wdata[1:0]};
            otp_prog_data <= otp_reg & {hold_reg.wdata[PARITY_OFF_BIT],
               hold_reg.wdata[1:0]};
            otp_prog_valid <= 1'b1;
         end
      end
   end

   // plain config registers; reserved bits are kept at zero
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         strobe_reg <= REG_RESET;
         dummy_reg <= REG_RESET;
         err_pin_reg <= REG_RESET;
         crc_pre_reg <= REG_RESET;
      end else if (wr_hit) begin
         case (hold_reg.addr)
            ADDR_STROBE: strobe_reg <= {6'h00, hold_reg.wdata[1:0]};
            ADDR_DUMMY: dummy_reg <= {5'h00, hold_reg.wdata[2:0]};
            ADDR_ERR_PIN: err_pin_reg <= {6'h00, hold_reg.wdata[1:0]};
            ADDR_CRC_PRE: crc_pre_reg <= hold_reg.wdata & 8'h71;
            default: strobe_reg <= strobe_reg;
         endcase
      end
   end

   // ecc status; an event in the clearing cycle survives the clear
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ecc_valid_reg <= 1'b0;
         ecc_kind_reg <= 3'h0;
         ecc_cnt_reg <= 4'h0;
         ecc_addr_reg <= '0;
      end else if (ecc_evt_valid) begin
         ecc_kind_reg <= (ecc_clear ? 3'h0 : ecc_kind_reg) | ecc_evt.kind;
         if (ecc_clear || ecc_cnt_reg == 4'h0) begin
            ecc_cnt_reg <= 4'h1;
         end else if (ecc_cnt_reg != ECC_CNT_MAX) begin
            ecc_cnt_reg <= ecc_cnt_reg + 4'h1;
         end
         if (ecc_clear || !ecc_valid_reg) begin
            ecc_addr_reg <= ecc_evt.addr;
            ecc_valid_reg <= 1'b1;
         end
      end else if (ecc_clear) begin
         ecc_valid_reg <= 1'b0;
         ecc_kind_reg <= 3'h0;
         ecc_cnt_reg <= 4'h0;
      end
   end

   // check failures are only recorded while checking is enabled
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_fail_reg <= 1'b0;
      end else if (cmd_check_fail && !otp_reg.parity_off_n) begin
         cmd_fail_reg <= 1'b1;
      end else if (wr_hit && hold_reg.addr == ADDR_CMD_ERR &&
            hold_reg.wdata == CLEAR_VALUE) begin
         cmd_fail_reg <= 1'b0;
      end
   end

   always_comb begin
      case (err_pin_reg[1:0])
         EPC_TWO_OR_DBL: err_match = ecc_kind_reg[KIND_TWO_BIT] |
            ecc_kind_reg[KIND_DBL_BIT];
         EPC_ANY: err_match = |ecc_kind_reg;
         EPC_TWO: err_match = ecc_kind_reg[KIND_TWO_BIT];
         default: err_match = ecc_kind_reg[KIND_ONE_BIT] |
            ecc_kind_reg[KIND_TWO_BIT];
      endcase
   end

   // decoded outputs, one cycle behind their registers
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         strobe_in_single_rate <= 1'b0;
         strobe_pre_cycle <= 1'b0;
         dummy_cycles <= DUMMY_BASE;
         error_out_pin_n <= 1'b1;
         crc_chunk_bytes <= CHUNK_MIN_BYTES;
         crc_pin_output_on <= 1'b0;
         parity_check_on <= 1'b0;
         cmd_parity_fail_flag <= 1'b0;
         ecc_fail_addr_valid <= 1'b0;
      end else begin
         strobe_in_single_rate <= strobe_reg[STRB_SINGLE_BIT] &&
            bus_mode == MODE_SRO;
         strobe_pre_cycle <= strobe_reg[STRB_PRE_BIT] &&
            bus_mode == MODE_DRO;
         dummy_cycles <= DUMMY_BASE - {1'b0, dummy_reg[2:0], 1'b0};
         error_out_pin_n <= ~err_match;
         crc_chunk_bytes <= CHUNK_MIN_BYTES <<
            crc_pre_reg[CRC_SIZE_LSB +: 2];
         crc_pin_output_on <= crc_pre_reg[CRC_PIN_BIT];
         parity_check_on <= ~otp_reg.parity_off_n;
         cmd_parity_fail_flag <= cmd_fail_reg;
         ecc_fail_addr_valid <= ecc_valid_reg;
      end
   end

   // preamble pattern only while the enable is set
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         preamble_active <= 1'b0;
         preamble_main <= 16'h0000;
         preamble_sio3 <= 16'h0000;
      end else if (!preamble_on_sync) begin
         preamble_active <= 1'b0;
         preamble_main <= 16'h0000;
         preamble_sio3 <= 16'h0000;
      end else begin
         preamble_active <= 1'b1;
         if (crc_pre_reg[PRE_CHOICE_BIT]) begin
            preamble_main <= PRE_B_ALL;
            preamble_sio3 <= PRE_B_ALL;
         end else begin
            preamble_main <= PRE_A_MAIN;
            preamble_sio3 <= PRE_A_SIO3;
         end
      end
   end
endmodule // fcrb_regbank
`default_nettype wire

/* File: verif/fcrb_regbank_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module fcrb_regbank_sva
   import fcrb_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic link_clk,
   input wire logic link_req_valid,
   input wire logic link_busy,
   input wire logic link_ack,
   input wire logic ecc_evt_valid,
   input wire logic cmd_check_fail,
   input wire logic [1:0] bus_mode,
   input wire logic strobe_in_single_rate,
   input wire logic strobe_pre_cycle,
   input wire logic [4:0] dummy_cycles,
   input wire logic error_out_pin_n,
   input wire logic [7:0] crc_chunk_bytes,
   input wire logic preamble_active,
   input wire logic [15:0] preamble_main,
   input wire logic [15:0] preamble_sio3,
   input wire logic cmd_parity_fail_flag,
   input wire logic ecc_fail_addr_valid
);
   a_ack_window:
   assert property (@(posedge link_clk) disable iff (!reset_n)
      link_req_valid && !link_busy && !link_ack |=>
      link_busy ##[2:4] link_ack)
      else $error("link answer outside window");
   a_ack_pulse:
   assert property (@(posedge link_clk) disable iff (!reset_n)
      link_ack |=> !link_ack) else $error("ack longer than one cycle");
   a_dummy_range:
   assert property (@(posedge core_clk) disable iff (!reset_n)
      !dummy_cycles[0] && dummy_cycles inside {[6:20]})
      else $error("dummy count out of range");
   a_chunk_size:
   assert property (@(posedge core_clk) disable iff (!reset_n)
      $onehot(crc_chunk_bytes[7:4]) && crc_chunk_bytes[3:0] == 4'h0)
      else $error("chunk size not 16 to 128");
   a_strobe_gate:
   assert property (@(posedge core_clk) disable iff (!reset_n)
      strobe_in_single_rate |->
      bus_mode == MODE_SRO || $past(bus_mode) == MODE_SRO)
      else $error("single-rate strobe outside sro");
   a_precyc_gate:
   assert property (@(posedge core_clk) disable iff (!reset_n)
      strobe_pre_cycle |->
      bus_mode == MODE_DRO || $past(bus_mode) == MODE_DRO)
      else $error("pre-cycle outside dro");
   a_flag_cause:
   assert property (@(posedge core_clk) disable iff (!reset_n)
      $rose(cmd_parity_fail_flag) |-> $past(cmd_check_fail, 2))
      else $error("check flag set without failure");
   a_valid_cause:
   assert property (@(posedge core_clk) disable iff (!reset_n)
      $rose(ecc_fail_addr_valid) |-> $past(ecc_evt_valid, 2))
      else $error("valid set without ecc event");
   a_pin_valid:
   assert property (@(posedge core_clk) disable iff (!reset_n)
      $fell(error_out_pin_n) |-> ecc_fail_addr_valid)
      else $error("error pin low with nothing recorded");
   a_pre_off:
   assert property (@(posedge core_clk) disable iff (!reset_n)
      !preamble_active |-> preamble_main == 16'h0 && preamble_sio3 == 16'h0)
      else $error("preamble driven while off");
   a_pre_pattern:
   assert property (@(posedge core_clk) disable iff (!reset_n)
      preamble_active |-> preamble_sio3 ==
      (preamble_main == PRE_B_ALL ? PRE_B_ALL : PRE_A_SIO3))
      else $error("preamble patterns mismatched");
   c_dro_pre: cover property (@(posedge core_clk) strobe_pre_cycle);
   c_pin_low: cover property (@(posedge core_clk) !error_out_pin_n);
   c_flag: cover property (@(posedge core_clk) cmd_parity_fail_flag);
endmodule // fcrb_regbank_sva
bind fcrb_regbank fcrb_regbank_sva u_sva (.core_clk, .reset_n, .link_clk,
   .link_req_valid, .link_busy, .link_ack, .ecc_evt_valid, .cmd_check_fail,
   .bus_mode, .strobe_in_single_rate, .strobe_pre_cycle, .dummy_cycles,
   .error_out_pin_n, .crc_chunk_bytes, .preamble_active, .preamble_main,
   .preamble_sio3, .cmd_parity_fail_flag, .ecc_fail_addr_valid);
`default_nettype wire

/* File: verif/fcrb_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module fcrb_host_model
   import fcrb_pkg::*;
(
   output logic link_clk,
   input wire logic reset_n,
   output logic link_req_valid,
   output var fcrb_pkg::fcrb_link_req_t link_req,
   input wire logic link_busy,
   input wire logic link_ack,
   input wire logic [7:0] link_rdata
);
   logic run = 1'b0;
   int miss = 0;
   // clock stands still between transfers, runs through reset
   initial begin
      link_clk = 1'b0;
      link_req_valid = 1'b0;
      link_req = '0;
      #23;
      forever #80 link_clk = (run || !reset_n) ? ~link_clk : 1'b0;
   end
   task automatic xfer(input logic w, input logic [31:0] a,
         input logic [7:0] d, output logic [7:0] q);
      int n;
      run = 1'b1;
      repeat (2) @(posedge link_clk);
      link_req_valid <= 1'b1;
      link_req <= '{w, a, d};
      n = 0;
      do begin
         @(posedge link_clk);
         n++;
      end while (link_ack !== 1'b1 && n < 20);
      if (link_ack !== 1'b1)
         miss++;
      q = link_rdata;
      link_req_valid <= 1'b0;
      // released lines change so a stale request is never mistaken
      link_req <= ~link_req;
      repeat (2) @(posedge link_clk);
      run = 1'b0;
   endtask
endmodule // fcrb_host_model
`default_nettype wire

/* File: verif/test_flash_config_register_bank_two.sv */
`timescale 1ns/1ns
`default_nettype none
module test_flash_config_register_bank_two;
   import fcrb_pkg::*;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic link_clk, link_req_valid, link_busy, link_ack;
   fcrb_link_req_t link_req;
   logic [7:0] link_rdata, q, v, crc_chunk_bytes;
   logic ecc_evt_valid = 1'b0;
   fcrb_ecc_evt_t ecc_evt = '0;
   logic cmd_check_fail = 1'b0;
   fcrb_otp_t otp_fuse = OTP_BLANK;
   logic preamble_on = 1'b0;
   logic [1:0] bus_mode;
   logic [4:0] dummy_cycles;
   logic [15:0] preamble_main, preamble_sio3;
   logic strobe_in_single_rate, strobe_pre_cycle, error_out_pin_n;
   logic crc_pin_output_on, preamble_active, parity_check_on;
   logic cmd_parity_fail_flag, ecc_fail_addr_valid;
   logic otp_prog_valid;
   fcrb_otp_t otp_prog_data;
   int progs = 0;
   logic [2:0] fz[5] = '{3'h7, 3'h5, 3'h6, 3'h4, 3'h3};
   logic [1:0] md[5] = '{MODE_SPI, MODE_DRO, MODE_SRO, MODE_SPI, MODE_SPI};
   logic [31:0] rw[6] = '{ADDR_BUS_MODE, ADDR_STROBE, ADDR_DUMMY,
      ADDR_ERR_PIN, ADDR_CRC_PRE, ADDR_ECC_STAT};
   logic [25:4] a1 = 22'h3a5c3c;
   logic [25:4] a2 = 22'h155aa5;
   int error_cnt = 0;
   int checked = 0;
   int cyc = 0;

   fcrb_regbank uut (.core_clk, .reset_n, .link_clk, .link_req_valid,
      .link_req, .link_busy, .link_ack, .link_rdata, .ecc_evt_valid,
      .ecc_evt, .cmd_check_fail, .otp_fuse, .preamble_on,
      .otp_prog_valid, .otp_prog_data, .bus_mode,
      .strobe_in_single_rate, .strobe_pre_cycle, .dummy_cycles,
      .error_out_pin_n, .crc_chunk_bytes, .crc_pin_output_on,
      .preamble_active, .preamble_main, .preamble_sio3, .parity_check_on,
      .cmd_parity_fail_flag, .ecc_fail_addr_valid);
   fcrb_host_model host (.link_clk, .reset_n, .link_req_valid, .link_req,
      .link_busy, .link_ack, .link_rdata);

   always #20 core_clk = ~core_clk;

   task automatic give_verdict;
      error_cnt += host.miss;
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (otp_prog_valid === 1'b1)
         progs++;
      if (cyc == 20000) begin
         error_cnt++;
         give_verdict;
      end
   end
   task automatic chk(input string n, input logic [15:0] e, g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cw(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // data is sent as given, reserved bits included; the bank masks them
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      host.xfer(1'b1, a, d, q);
      cw(3);
   endtask
   task automatic rd(input logic [31:0] a, input logic [7:0] e);
      host.xfer(1'b0, a, 8'h00, q);
      chk($sformatf("read %h", a), {8'h0, e}, {8'h0, q});
   endtask
   // reset spans two link edges, not just two core edges
   task automatic rst(input fcrb_otp_t f);
      @(posedge core_clk);
      reset_n <= 1'b0;
      otp_fuse <= f;
      cw(10);
      reset_n <= 1'b1;
      cw(10);
   endtask
   task automatic ev(input logic [2:0] k, input logic [25:4] a);
      @(posedge core_clk);
      ecc_evt_valid <= 1'b1;
      ecc_evt <= '{k, a};
      @(posedge core_clk);
      ecc_evt_valid <= 1'b0;
      cw(3);
   endtask
   task automatic cfail;
      @(posedge core_clk);
      cmd_check_fail <= 1'b1;
      @(posedge core_clk);
      cmd_check_fail <= 1'b0;
      cw(3);
   endtask

   initial begin
      for (int i = 0; i < 5; i++) begin
         rst(fz[i]);
         chk("bus_mode", 16'(md[i]), 16'(bus_mode));
         rd(ADDR_BUS_MODE, {6'h0, md[i]});
         v = BOOT_RSV_ONES | {4'h0, fz[i][2], 1'b0, fz[i][1:0]};
         rd(ADDR_BOOT_DEF, v);
         chk("parity", 16'(!fz[i][2]), 16'(parity_check_on));
         cfail;
         chk("flag", 16'(!fz[i][2]), 16'(cmd_parity_fail_flag));
      end
      rd(ADDR_CMD_ERR, 8'h10);
      wr(ADDR_CMD_ERR, 8'h10);
      rd(ADDR_CMD_ERR, 8'h10);
      wr(ADDR_CMD_ERR, CLEAR_VALUE);
      rd(ADDR_CMD_ERR, 8'h00);
      chk("flag", 16'(0), 16'(cmd_parity_fail_flag));
      wr(ADDR_BOOT_DEF, 8'hf6);
      rd(ADDR_BOOT_DEF, 8'hf6);
      chk("prog", 16'h0002, {13'h0, otp_prog_data});
      chk("progs", 16'(1), 16'(progs));
      chk("parity", 16'(1), 16'(parity_check_on));
      foreach (rw[i]) rd(rw[i], REG_RESET);
      rd(32'h00000100, 8'h00);
      chk("dummy", 16'(DUMMY_BASE), 16'(dummy_cycles));
      chk("chunk", 16'(CHUNK_MIN_BYTES), 16'(crc_chunk_bytes));
      wr(ADDR_BUS_MODE, {6'h0, MODE_SRO});
      wr(ADDR_STROBE, 8'h03);
      chk("sro", 16'(MODE_SRO), 16'(bus_mode));
      chk("strobe", 16'(1), 16'(strobe_in_single_rate));
      chk("precyc", 16'(0), 16'(strobe_pre_cycle));
      wr(ADDR_BUS_MODE, 8'h00);
      wr(ADDR_BUS_MODE, {6'h0, MODE_DRO});
      chk("dro", 16'(MODE_DRO), 16'(bus_mode));
      chk("strobe", 16'(0), 16'(strobe_in_single_rate));
      chk("precyc", 16'(1), 16'(strobe_pre_cycle));
      rd(ADDR_STROBE, 8'h03);
      wr(ADDR_BUS_MODE, 8'h00);
      for (int k = 0; k < 8; k++) begin
         wr(ADDR_DUMMY, 8'(k));
         rd(ADDR_DUMMY, 8'(k));
         chk("dummy", 16'(DUMMY_BASE - 5'(2 * k)), 16'(dummy_cycles));
      end
      preamble_on <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         v = {1'b0, 2'(k), 1'b1, 3'h0, k[0]};
         wr(ADDR_CRC_PRE, v);
         rd(ADDR_CRC_PRE, v);
         chk("chunk", 16'(CHUNK_MIN_BYTES << k), 16'(crc_chunk_bytes));
         chk("crc pin", 16'(1), 16'(crc_pin_output_on));
         chk("main", k[0] ? PRE_B_ALL : PRE_A_MAIN, preamble_main);
         chk("sio3", k[0] ? PRE_B_ALL : PRE_A_SIO3, preamble_sio3);
      end
      cw(1);
      preamble_on <= 1'b0;
      wr(ADDR_CRC_PRE, 8'h00);
      chk("crc pin", 16'(0), 16'(crc_pin_output_on));
      chk("pre off", 16'(0), preamble_main);
      for (int c = 0; c < 4; c++) begin
         wr(ADDR_ERR_PIN, 8'(c));
         ev(3'b001, a1);
         chk("pin", 16'(!c[0]), 16'(error_out_pin_n));
         wr(ADDR_ECC_STAT, CLEAR_VALUE);
      end
      wr(ADDR_ERR_PIN, {6'h0, EPC_TWO_OR_DBL});
      ev(3'b100, a2);
      chk("pin", 16'(0), 16'(error_out_pin_n));
      wr(ADDR_ECC_STAT, CLEAR_VALUE);
      wr(ADDR_ERR_PIN, {6'h0, EPC_TWO});
      ev(3'b001, a1);
      chk("valid", 16'(1), 16'(ecc_fail_addr_valid));
      chk("pin", 16'(1), 16'(error_out_pin_n));
      ev(3'b010, a2);
      chk("pin", 16'(0), 16'(error_out_pin_n));
      rd(ADDR_ECC_STAT, 8'hb2);
      host.xfer(1'b0, ADDR_ECC_A0, 8'h00, q);
      chk("addr0", 16'(a1[7:4]), 16'(q[7:4]));
      rd(ADDR_ECC_A1, a1[15:8]);
      rd(ADDR_ECC_A2, a1[23:16]);
      rd(ADDR_ECC_A3, {6'h0, a1[25:24]});
      repeat (14) ev(3'b001, a2);
      rd(ADDR_ECC_STAT, 8'hbf);
      wr(ADDR_ECC_STAT, 8'h55);
      rd(ADDR_ECC_STAT, 8'hbf);
      wr(ADDR_ECC_STAT, CLEAR_VALUE);
      rd(ADDR_ECC_STAT, 8'h00);
      chk("valid", 16'(0), 16'(ecc_fail_addr_valid));
      chk("pin", 16'(1), 16'(error_out_pin_n));
      give_verdict;
   end
endmodule // test_flash_config_register_bank_two
`default_nettype wire
